//--- hw/metering_cfg_pkg.sv
package metering_cfg_pkg;

  // Avalon-MM geometry: byte address, one 32-bit word per register
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BE_W      = 4;
  localparam int unsigned ADDR_W    = 18;
  localparam int unsigned IDX_SHIFT = 2;
  localparam int unsigned IDX_W     = 16;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_MEAS_MODE    = 16'hE700;
  localparam logic [15:0] IDX_ACCUM_MODE   = 16'hE701;
  localparam logic [15:0] IDX_EVENT_STATUS = 16'hE710;
  localparam logic [15:0] IDX_EVENT_MASK   = 16'hE711;

  // measurement_mode_select fields
  localparam int unsigned REV_ACT_SRC_BIT   = 0;
  localparam int unsigned REV_REACT_SRC_BIT = 1;
  localparam int unsigned PEAK_LSB          = 2;
  localparam logic [7:0]  MEAS_MODE_RESET   = 8'h1C;
  localparam logic [7:0]  MEAS_MODE_WMASK   = 8'h1F;

  // energy_accumulation_mode fields
  localparam int unsigned ACT_FIELD_LSB    = 0;
  localparam int unsigned REACT_FIELD_LSB  = 2;
  localparam logic [7:0]  ACCUM_MODE_RESET = 8'h00;
  localparam logic [7:0]  ACCUM_MODE_WMASK = 8'h0F;

  // Accumulation codes shared by both fields
  typedef logic [1:0] accum_code_t;
  localparam accum_code_t ACC_SIGNED       = 2'h0;
  localparam accum_code_t ACT_POSITIVE     = 2'h1;
  localparam accum_code_t REACT_BY_ACT_SGN = 2'h2;
  localparam accum_code_t ACC_ABSOLUTE     = 2'h3;

  // primary_event_status layout, mask register is the same
  localparam int unsigned STATUS_W        = 16;
  localparam int unsigned REV_ACT_LSB     = 6;
  localparam int unsigned REV_REACT_LSB   = 10;
  localparam logic [15:0] STATUS_IMPL     = 16'h1DC0;
  localparam logic [15:0] EVENT_MASK_INIT = 16'h0000;

  // Three phases, each with a total and a fundamental lane
  localparam int unsigned NUM_PHASES = 3;
  localparam int unsigned NUM_LANES  = 6;

endpackage : metering_cfg_pkg

//--- hw/accum_lane_if.sv
`timescale 1ns/1ns
`default_nettype none

// Carries the sample set and both accumulation codes to the term unit
interface accum_lane_if #(parameter int unsigned W = 24);
  logic                                    start;
  metering_cfg_pkg::accum_code_t           act_mode;
  metering_cfg_pkg::accum_code_t           react_mode;
  logic [metering_cfg_pkg::NUM_LANES-1:0][W-1:0] act;
  logic [metering_cfg_pkg::NUM_LANES-1:0][W-1:0] react;
  logic [metering_cfg_pkg::NUM_LANES-1:0][W:0]   act_energy;
  logic [metering_cfg_pkg::NUM_LANES-1:0][W:0]   act_pulse;
  logic [metering_cfg_pkg::NUM_LANES-1:0][W:0]   react_term;
  logic                                    done;

  modport ctrl (output start, act_mode, react_mode, act, react,
                input act_energy, act_pulse, react_term, done);
  modport unit (input start, act_mode, react_mode, act, react,
                output act_energy, act_pulse, react_term, done);
endinterface : accum_lane_if

`default_nettype wire

//--- hw/accum_term_unit.sv
`timescale 1ns/1ns
`default_nettype none

module accum_term_unit #(
  parameter int unsigned W = 24
) (
  // Clock, reset, enable
  input wire logic    clk,
  input wire logic    rst,
  input wire logic    ce,
  // Sample set and results
  accum_lane_if.unit  lane
);

  localparam int unsigned NL = metering_cfg_pkg::NUM_LANES;

  typedef struct packed {
    logic                done;
    logic [NL-1:0][W:0]  act_energy;
    logic [NL-1:0][W:0]  act_pulse;
    logic [NL-1:0][W:0]  react_term;
  } unit_state_t;

  unit_state_t state_reg;
  unit_state_t state_next;

  // Sign extension by one bit so that the magnitude of the most
  // negative sample still fits
  function automatic logic signed [W:0] widen(input logic [W-1:0] x);
    widen = $signed({x[W-1], x});
  endfunction

  function automatic logic signed [W:0] magnitude(input logic [W-1:0] x);
    magnitude = x[W-1] ? -widen(x) : widen(x);
  endfunction

  // Term added to the watt-hour register
  function automatic logic signed [W:0] act_energy_term(
      input metering_cfg_pkg::accum_code_t m, input logic [W-1:0] p);
    case (m)
      metering_cfg_pkg::ACT_POSITIVE: begin
        act_energy_term = p[W-1] ? '0 : widen(p);
      end
      metering_cfg_pkg::ACC_ABSOLUTE: begin
        act_energy_term = magnitude(p);
      end
      default: begin
        act_energy_term = widen(p);
      end
    endcase
  endfunction

  // Term fed to the pulse converter; positive-only still pulses signed
  function automatic logic signed [W:0] act_pulse_term(
      input metering_cfg_pkg::accum_code_t m, input logic [W-1:0] p);
    case (m)
      metering_cfg_pkg::ACC_ABSOLUTE: begin
        act_pulse_term = magnitude(p);
      end
      default: begin
        act_pulse_term = widen(p);
      end
    endcase
  endfunction

  // Reactive term, the same for the var-hour register and the pulses
  function automatic logic signed [W:0] react_term_calc(
      input metering_cfg_pkg::accum_code_t m,
      input logic [W-1:0] q, input logic [W-1:0] p);
    case (m)
      metering_cfg_pkg::REACT_BY_ACT_SGN: begin
        react_term_calc = p[W-1] ? -widen(q) : widen(q);
      end
      metering_cfg_pkg::ACC_ABSOLUTE: begin
        react_term_calc = magnitude(q);
      end
      default: begin
        react_term_calc = widen(q);
      end
    endcase
  endfunction

  // Terms are formed only when a sample set is offered, so a mode
  // written between two sets applies to the next one
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (lane.start) begin
      state_next.done = 1'b1;
      for (int i = 0; i < NL; i++) begin
        state_next.act_energy[i] =
          act_energy_term(lane.act_mode, lane.act[i]);
        state_next.act_pulse[i] =
          act_pulse_term(lane.act_mode, lane.act[i]);
        state_next.react_term[i] =
          react_term_calc(lane.react_mode, lane.react[i],
                          lane.act[i]);
      end
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign lane.done       = state_reg.done;
  assign lane.act_energy = state_reg.act_energy;
  assign lane.act_pulse  = state_reg.act_pulse;
  assign lane.react_term = state_reg.react_term;

endmodule : accum_term_unit

`default_nettype wire

//--- hw/metering_mode_accum_config.sv
`timescale 1ns/1ns
`default_nettype none

module metering_mode_accum_config #(
  parameter int unsigned W = 24
) (
  // Clock, reset, enable
  input  wire logic                            CLK,
  input  wire logic                            RST,
  input  wire logic                            CE,
  // Avalon-MM slave
  input  wire logic [metering_cfg_pkg::ADDR_W-1:0] ADDRESS,
  input  wire logic                            READ,
  input  wire logic                            WRITE,
  input  wire logic [metering_cfg_pkg::DATA_W-1:0] WRITEDATA,
  input  wire logic [metering_cfg_pkg::BE_W-1:0]   BYTEENABLE,
  output logic [metering_cfg_pkg::DATA_W-1:0]      READDATA,
  output logic                                 WAITREQUEST,
  // Power samples, one strobe per set, from the same clock domain
  input  wire logic                            SAMPLE_VALID,
  input  wire logic [2:0][W-1:0]               ACT_TOTAL,
  input  wire logic [2:0][W-1:0]               ACT_FUND,
  input  wire logic [2:0][W-1:0]               REACT_TOTAL,
  input  wire logic [2:0][W-1:0]               REACT_FUND,
  // Accumulation terms, lanes 0..2 total A..C, 3..5 fundamental A..C
  output logic [5:0][W:0]                      ACT_ENERGY_TERM,
  output logic [5:0][W:0]                      ACT_PULSE_TERM,
  output logic [5:0][W:0]                      REACT_TERM,
  output logic                                 TERM_VALID,
  // Peak detection phase selection and interrupt
  output logic [2:0]                           PEAK_INCLUDE,
  output logic                                 IRQ
);

  localparam int unsigned NP = metering_cfg_pkg::NUM_PHASES;
  localparam int unsigned SW = metering_cfg_pkg::STATUS_W;

  // A sample must carry a sign bit and at least one magnitude bit
  if (W < 2) begin : g_width_check
    $error("accumulation sample width W must be at least 2");
  end

  typedef struct packed {
    logic                                ack;
    logic [metering_cfg_pkg::DATA_W-1:0] rdata;
    logic [7:0]                          meas_mode;
    logic [7:0]                          accum_mode;
    logic [SW-1:0]                       status;
    logic [SW-1:0]                       mask;
  } cfg_state_t;

  cfg_state_t state_reg;
  cfg_state_t state_next;

  accum_lane_if #(.W(W)) lane ();

  // Register index out of the byte address
  function automatic logic [metering_cfg_pkg::IDX_W-1:0] reg_index(
      input logic [metering_cfg_pkg::ADDR_W-1:0] a);
    reg_index = a[metering_cfg_pkg::ADDR_W-1:metering_cfg_pkg::IDX_SHIFT];
  endfunction

  // Byte-lane merge; bits outside the write mask keep their value
  function automatic logic [SW-1:0] merge16(
      input logic [SW-1:0] old_v, input logic [SW-1:0] new_v,
      input logic [1:0] be, input logic [SW-1:0] wmask);
    logic [SW-1:0] lane_m;
    lane_m  = {{8{be[1]}}, {8{be[0]}}} & wmask;
    merge16 = (old_v & ~lane_m) | (new_v & lane_m);
  endfunction

  function automatic logic [7:0] merge8(
      input logic [7:0] old_v, input logic [7:0] new_v,
      input logic be, input logic [7:0] wmask);
    logic [7:0] lane_m;
    lane_m = {8{be}} & wmask;
    merge8 = (old_v & ~lane_m) | (new_v & lane_m);
  endfunction

  // Read mux; unmapped indices read as zero
  function automatic logic [metering_cfg_pkg::DATA_W-1:0] read_mux(
      input logic [metering_cfg_pkg::IDX_W-1:0] idx, input cfg_state_t s);
    read_mux = '0;
    case (idx)
      metering_cfg_pkg::IDX_MEAS_MODE: begin
        read_mux[7:0] = s.meas_mode;
      end
      metering_cfg_pkg::IDX_ACCUM_MODE: begin
        read_mux[7:0] = s.accum_mode;
      end
      metering_cfg_pkg::IDX_EVENT_STATUS: begin
        read_mux[SW-1:0] = s.status;
      end
      metering_cfg_pkg::IDX_EVENT_MASK: begin
        read_mux[SW-1:0] = s.mask;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  endfunction

  logic [metering_cfg_pkg::IDX_W-1:0] bus_idx;
  logic                               bus_req;
  logic                               wr_fire;
  logic [NP-1:0]                      rev_act_evt;
  logic [NP-1:0]                      rev_react_evt;
  logic [SW-1:0]                      evt_vec;
  logic [SW-1:0]                      w1c_vec;

  assign bus_idx = reg_index(ADDRESS);
  assign bus_req = READ | WRITE;
  // A write lands only at the edge where waitrequest is low
  assign wr_fire = WRITE & state_reg.ack;

  // Reverse-power events, sources picked by the mode register
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      if (state_reg.meas_mode[metering_cfg_pkg::REV_ACT_SRC_BIT]) begin
        rev_act_evt[i] = SAMPLE_VALID & ACT_FUND[i][W-1];
      end else begin
        rev_act_evt[i] = SAMPLE_VALID & ACT_TOTAL[i][W-1];
      end
      if (state_reg.meas_mode[metering_cfg_pkg::REV_REACT_SRC_BIT]) begin
        rev_react_evt[i] = SAMPLE_VALID & REACT_FUND[i][W-1];
      end else begin
        rev_react_evt[i] = SAMPLE_VALID & REACT_TOTAL[i][W-1];
      end
    end
  end

  // Events placed at their status bit positions
  always_comb begin
    evt_vec = '0;
    evt_vec[metering_cfg_pkg::REV_ACT_LSB +: NP]   = rev_act_evt;
    evt_vec[metering_cfg_pkg::REV_REACT_LSB +: NP] = rev_react_evt;
  end

  // Write-one-to-clear pattern for the status register
  always_comb begin
    w1c_vec = '0;
    if (wr_fire && bus_idx == metering_cfg_pkg::IDX_EVENT_STATUS) begin
      w1c_vec = merge16('0, WRITEDATA[SW-1:0], BYTEENABLE[1:0],
                        metering_cfg_pkg::STATUS_IMPL);
    end
  end

  // Next state: bus handshake, register writes, sticky status
  always_comb begin
    state_next = state_reg;
    // One wait cycle per access, then the answer stands for one edge
    state_next.ack = bus_req & ~state_reg.ack;
    if (bus_req && !state_reg.ack) begin
      state_next.rdata = read_mux(bus_idx, state_reg);
    end
    if (wr_fire) begin
      case (bus_idx)
        metering_cfg_pkg::IDX_MEAS_MODE: begin
          state_next.meas_mode = merge8(state_reg.meas_mode,
            WRITEDATA[7:0], BYTEENABLE[0],
            metering_cfg_pkg::MEAS_MODE_WMASK);
        end
        metering_cfg_pkg::IDX_ACCUM_MODE: begin
          state_next.accum_mode = merge8(state_reg.accum_mode,
            WRITEDATA[7:0], BYTEENABLE[0],
            metering_cfg_pkg::ACCUM_MODE_WMASK);
        end
        metering_cfg_pkg::IDX_EVENT_MASK: begin
          state_next.mask = merge16(state_reg.mask, WRITEDATA[SW-1:0],
            BYTEENABLE[1:0], metering_cfg_pkg::STATUS_IMPL);
        end
        default: begin
          state_next.mask = state_reg.mask;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle
    state_next.status = ((state_reg.status & ~w1c_vec) | evt_vec)
                        & metering_cfg_pkg::STATUS_IMPL;
  end

  // State register; reset gives only the three peak bits set
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg            <= '0;
      state_reg.meas_mode  <= metering_cfg_pkg::MEAS_MODE_RESET;
      state_reg.accum_mode <= metering_cfg_pkg::ACCUM_MODE_RESET;
      state_reg.mask       <= metering_cfg_pkg::EVENT_MASK_INIT;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // Sample set to the term unit, modes taken straight from registers
  assign lane.start      = SAMPLE_VALID;
  assign lane.act_mode   = state_reg.accum_mode[
    metering_cfg_pkg::ACT_FIELD_LSB +: 2];
  assign lane.react_mode = state_reg.accum_mode[
    metering_cfg_pkg::REACT_FIELD_LSB +: 2];
  assign lane.act        = {ACT_FUND, ACT_TOTAL};
  assign lane.react      = {REACT_FUND, REACT_TOTAL};

  accum_term_unit #(
    .W (W)
  ) u_terms (
    .clk  (CLK),
    .rst  (RST),
    .ce   (CE),
    .lane (lane)
  );

  // Bus answer; waitrequest is combinational, data come from a register
  assign WAITREQUEST = bus_req & ~state_reg.ack;
  assign READDATA    = state_reg.rdata;

  // Results and configuration levels
  assign ACT_ENERGY_TERM = lane.act_energy;
  assign ACT_PULSE_TERM  = lane.act_pulse;
  assign REACT_TERM      = lane.react_term;
  assign TERM_VALID      = lane.done;
  assign PEAK_INCLUDE    =
    state_reg.meas_mode[metering_cfg_pkg::PEAK_LSB +: NP];
  // Level interrupt while any unmasked sticky bit is set
  assign IRQ = |(state_reg.status & state_reg.mask);

endmodule : metering_mode_accum_config

`default_nettype wire

//--- verif/metering_mode_accum_config_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module mode_accum_asserts #(
  parameter int unsigned W = 24
) (
  // Clock, reset, enable
  input wire logic             CLK,
  input wire logic             RST,
  input wire logic             CE,
  // Register bus
  input wire logic [17:0]      ADDRESS,
  input wire logic             READ,
  input wire logic             WRITE,
  input wire logic [31:0]      WRITEDATA,
  input wire logic [3:0]       BYTEENABLE,
  input wire logic             WAITREQUEST,
  // Samples and terms
  input wire logic             SAMPLE_VALID,
  input wire logic [2:0][W-1:0] ACT_TOTAL,
  input wire logic [2:0][W-1:0] ACT_FUND,
  input wire logic [2:0][W-1:0] REACT_TOTAL,
  input wire logic [5:0][W:0]  ACT_ENERGY_TERM,
  input wire logic [5:0][W:0]  ACT_PULSE_TERM,
  input wire logic [5:0][W:0]  REACT_TERM,
  input wire logic             TERM_VALID,
  // Peak selection and interrupt
  input wire logic [2:0]       PEAK_INCLUDE,
  input wire logic             IRQ
);
  logic wr_done;
  logic wmeas;
  logic wclr;

  // Completing writes that the assertions key on
  assign wr_done = WRITE && !WAITREQUEST && CE;
  assign wmeas = wr_done && BYTEENABLE[0]
                 && ADDRESS == {metering_cfg_pkg::IDX_MEAS_MODE, 2'b00};
  assign wclr = wr_done && BYTEENABLE[1:0] == 2'b11 && !SAMPLE_VALID
                && WRITEDATA[15:0] == 16'hFFFF
                && ADDRESS == {metering_cfg_pkg::IDX_EVENT_STATUS, 2'b00};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  wait_state_a: assert property ($rose(READ || WRITE) && CE
    |-> WAITREQUEST ##1 !WAITREQUEST) else $error("wait state wrong");
  term_valid_a: assert property ($past(CE && !RST)
    |-> TERM_VALID == $past(SAMPLE_VALID)) else $error("term strobe wrong");
  peak_write_a: assert property (wmeas
    |=> PEAK_INCLUDE == $past(WRITEDATA[4:2])) else $error("peak not set");
  peak_hold_a: assert property (!wmeas
    |=> $stable(PEAK_INCLUDE)) else $error("peak changed");
  energy_pos_a: assert property (SAMPLE_VALID && CE && !ACT_TOTAL[0][W-1]
    |=> ACT_ENERGY_TERM[0] == {1'b0, $past(ACT_TOTAL[0])})
    else $error("energy term wrong");
  pulse_neg_a: assert property (SAMPLE_VALID && CE && ACT_FUND[0][W-1]
    |=> ACT_PULSE_TERM[3] == {1'b1, $past(ACT_FUND[0])}
     || ACT_PULSE_TERM[3] == -{1'b1, $past(ACT_FUND[0])})
    else $error("pulse term wrong");
  react_pos_a: assert property (SAMPLE_VALID && CE && !REACT_TOTAL[1][W-1]
    && !ACT_TOTAL[1][W-1] |=> REACT_TERM[1] == {1'b0, $past(REACT_TOTAL[1])})
    else $error("reactive term wrong");
  irq_clear_a: assert property (wclr |=> !IRQ)
    else $error("interrupt not cleared");
  terms_hold_a: assert property (!SAMPLE_VALID
    |=> $stable(REACT_TERM)) else $error("terms changed");
endmodule // mode_accum_asserts

bind metering_mode_accum_config mode_accum_asserts #(.W(W)) chk (.*);

`default_nettype wire

//--- verif/sample_source.sv
`timescale 1ns/1ns
`default_nettype none

module sample_source #(
  parameter int unsigned W = 8
) (
  // Clock and request
  input wire logic         clk,
  input wire logic         go,
  // Sample set
  output logic             valid,
  output logic [2:0][W-1:0] at,
  output logic [2:0][W-1:0] af,
  output logic [2:0][W-1:0] rt,
  output logic [2:0][W-1:0] rf
);
  logic [31:0] seed = 32'h86C6_D399;

  // Fresh data with the strobe; between sets the lines toggle so stale
  // values cannot pass for a sample
  always @(posedge clk) begin
    valid <= go;
    for (int i = 0; i < 3; i++) begin
      at[i] <= go ? W'($random(seed)) : ~at[i];
      af[i] <= go ? W'($random(seed)) : ~af[i];
      rt[i] <= go ? W'($random(seed)) : ~rt[i];
      rf[i] <= go ? W'($random(seed)) : ~rf[i];
    end
  end
endmodule // sample_source

`default_nettype wire

//--- verif/metering_mode_accum_config_tb.sv
`timescale 1ns/1ns
`default_nettype none

module metering_mode_accum_config_tb;
  localparam int unsigned WD = 8;
  localparam logic [17:0] A_MEAS = {metering_cfg_pkg::IDX_MEAS_MODE, 2'b00};
  localparam logic [17:0] A_ACC = {metering_cfg_pkg::IDX_ACCUM_MODE, 2'b00};
  localparam logic [17:0] A_STAT = {metering_cfg_pkg::IDX_EVENT_STATUS, 2'b00};
  localparam logic [17:0] A_MASK = {metering_cfg_pkg::IDX_EVENT_MASK, 2'b00};
  typedef logic [2:0][5:0][WD:0] note_t;

  logic clk, rst, ce, go, rd, wr, wreq, irq, sv, tv;
  logic [17:0] addr;
  logic [31:0] wdata, rdata, v, seed;
  logic [3:0] be;
  logic [2:0] peak;
  logic [2:0][WD-1:0] at, af, rt, rf;
  logic [5:0][WD:0] ae, ap, rterm;
  note_t tq[$];
  logic [31:0] rq[$];
  logic [1:0] am, rm;
  logic [7:0] mm;
  logic [15:0] stat;
  int bad_count, tests_run;

  metering_mode_accum_config #(.W(WD)) uut (.CLK(clk), .RST(rst), .CE(ce),
    .ADDRESS(addr), .READ(rd), .WRITE(wr), .WRITEDATA(wdata),
    .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(wreq),
    .SAMPLE_VALID(sv), .ACT_TOTAL(at), .ACT_FUND(af), .REACT_TOTAL(rt),
    .REACT_FUND(rf), .ACT_ENERGY_TERM(ae), .ACT_PULSE_TERM(ap),
    .REACT_TERM(rterm), .TERM_VALID(tv), .PEAK_INCLUDE(peak), .IRQ(irq));
  sample_source #(.W(WD)) src (.clk(clk), .go(go), .valid(sv), .at(at),
    .af(af), .rt(rt), .rf(rf));

  always #2 clk = ~clk;

  // One bus access; a read notes its expected data first
  task automatic acc(input logic w, input logic [17:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    if (!w) rq.push_back(d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    be <= b;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Note expected terms and flags for each sample set driven
  always @(posedge clk) begin : note_terms
    logic [WD-1:0] p, q;
    logic [WD:0] sp, sq;
    note_t e;
    if (sv === 1'b1) begin
      for (int i = 0; i < 6; i++) begin
        p = (i < 3) ? at[i % 3] : af[i % 3];
        q = (i < 3) ? rt[i % 3] : rf[i % 3];
        sp = {p[WD-1], p};
        sq = {q[WD-1], q};
        e[2][i] = (am == 2'h3 && p[WD-1]) ? -sp
                : (am == 2'h1 && p[WD-1]) ? '0 : sp;
        e[1][i] = (am == 2'h3 && p[WD-1]) ? -sp : sp;
        e[0][i] = ((rm == 2'h2 && p[WD-1]) || (rm == 2'h3 && q[WD-1]))
                ? -sq : sq;
      end
      for (int i = 0; i < 3; i++) begin
        stat[6+i] |= mm[0] ? af[i][WD-1] : at[i][WD-1];
        stat[10+i] |= mm[1] ? rf[i][WD-1] : rt[i][WD-1];
      end
      tq.push_back(e);
    end
  end

  // Compare each result with the oldest note as it appears
  always @(posedge clk) begin
    if (rd && wreq === 1'b0) begin
      tests_run++;
      if (rdata !== rq.pop_front()) begin
        bad_count++;
        $display("wrong value at %0t: read data %h", $time, rdata);
      end
    end
    if (tv === 1'b1) begin
      tests_run++;
      if ({ae, ap, rterm} !== tq.pop_front()) begin
        bad_count++;
        $display("wrong value at %0t: terms", $time);
      end
    end
  end

  // Cut a hang short
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial begin
    clk = 0;
    {rst, ce, addr, wdata, be} = '1;
    {go, rd, wr} = '0;
    seed = 32'h86C6_D399;
    {am, rm, stat, bad_count, tests_run} = '0;
    mm = 8'h1C;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped place, reserved bits, disabled lane
    acc(0, A_MEAS, 32'h0000_001C, 4'hF);
    acc(0, A_ACC, 32'h0000_0000, 4'hF);
    acc(0, A_STAT, 32'h0000_0000, 4'hF);
    acc(0, A_MASK, 32'h0000_0000, 4'hF);
    acc(0, 18'h0_0000, 32'h0000_0000, 4'hF);
    acc(1, A_MEAS, 32'hFFFF_FFFF, 4'hF);
    acc(0, A_MEAS, 32'h0000_001F, 4'hF);
    acc(1, A_MEAS, 32'h0000_0000, 4'h2);
    acc(0, A_MEAS, 32'h0000_001F, 4'hF);
    // Enable low stretches the wait; the write lands only after it
    ce <= 1'b0;
    fork
      acc(1, A_MEAS, 32'h0000_0004, 4'h1);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    acc(0, A_MEAS, 32'h0000_0004, 4'hF);
    // Every pair of accumulation codes, random source and peak bits
    for (int k = 0; k < 16; k++) begin
      v = $random(seed);
      acc(1, A_ACC, {v[31:4], 4'(k)}, 4'hF);
      am = 2'(k);
      rm = 2'(k >> 2);
      acc(0, A_ACC, 32'(k), 4'hF);
      acc(1, A_MEAS, v, 4'hF);
      mm = v[7:0] & 8'h1F;
      acc(0, A_MEAS, {24'h0, mm}, 4'hF);
      tests_run++;
      if (peak !== mm[4:2]) begin
        bad_count++;
        $display("wrong value at %0t: peak include", $time);
      end
      // Back-to-back sample sets
      @(posedge clk) go <= 1'b1;
      repeat (8) @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      acc(1, A_MASK, 32'h0000_1DC0, 4'hF);
      acc(0, A_STAT, {16'h0, stat}, 4'hF);
      tests_run++;
      if (irq !== (stat != 0)) begin
        bad_count++;
        $display("wrong value at %0t: interrupt raised", $time);
      end
      acc(1, A_STAT, 32'h0000_FFFF, 4'hF);
      stat = '0;
      acc(0, A_STAT, 32'h0000_0000, 4'hF);
      tests_run++;
      if (irq !== 1'b0) begin
        bad_count++;
        $display("wrong value at %0t: interrupt cleared", $time);
      end
    end
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // metering_mode_accum_config_tb

`default_nettype wire
